// [sau_pkg.sv]
// Package for the signed arithmetic unit: operation codes, limits, carriers.
// Assumes a sequencer that supplies operands and writes results back.
package sau_pkg;

    // Word widths
    localparam int SAU_W = 16;
    localparam int SAU_DW = 32;

    // Signed 16-bit limits
    localparam logic signed [15:0] SAU_MAX = 16'sh7FFF;
    localparam logic signed [15:0] SAU_MIN = -16'sh8000;
    localparam logic signed [15:0] SAU_ZERO = 16'sh0000;
    localparam logic signed [15:0] SAU_NEG_ONE = -16'sh0001;

    // Latency figures in clock cycles
    localparam int SAU_FAST_CYC = 1;
    localparam int SAU_SLOW_CYC = 2;

    // Operation selector
    typedef enum logic [1:0] {
        SAU_OP_ADD = 2'h0,
        SAU_OP_SUB = 2'h1,
        SAU_OP_MUL = 2'h2,
        SAU_OP_DIV = 2'h3
    } sau_op_t;

    // Request carried from the sequencer
    typedef struct packed {
        sau_op_t op;
        logic plain;
        logic signed [15:0] a;
        logic signed [15:0] b;
    } sau_req_t;

    // Result carried back to the sequencer
    typedef struct packed {
        logic wr_lo;
        logic wr_hi;
        logic [15:0] lo;
        logic [15:0] hi;
    } sau_res_t;

endpackage : sau_pkg

// [sau_unit.sv]
// Signed 16-bit arithmetic unit: saturating add and subtract, multiply to
// a double word, and divide with quotient and remainder.
// Assumes the sequencer holds the request stable while rung_i is high and
// writes back lo to the base word and hi to the next word on done_o.
//
// Contract
// - Add overflow stores max, output on
// - Subtract writes first minus second operand
// - Subtract out of range clamps, output on
// - Subtract in range exact, output off
// - Subtract underflow stores most negative, output on
// - Multiply writes full 32-bit signed product
// - Product high to next word, output on
// - Rung off: no calculation, output off
// - Divide: quotient base word, remainder next
// - Zero divisor: no divide, error flag set
// - Plain register operands take faster path
// - Divide ok: output on, truncate toward zero
`timescale 1ns/1ns
module sau_unit
    import sau_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Request from the sequencer
    input wire logic rung_i,
    input wire logic start_i,
    input wire sau_req_t req_i,
    // Results back to the sequencer
    output sau_res_t res_o,
    output logic done_o,
    output logic out_o,
    output logic division_error_flag_o
);

    // Saturate a 17-bit value into 16 bits
    function automatic logic [16:0] sat16(input logic signed [16:0] v);
        logic [16:0] r;
        r = {1'b0, v[15:0]};
        if (v > 17'sd32767) begin
            r = {1'b1, SAU_MAX};
        end else if (v < -17'sd32768) begin
            r = {1'b1, SAU_MIN};
        end
        return r;
    endfunction : sat16

    // Execution states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_DONE = 3'b100
    } sau_st_t;

    sau_st_t state; // Current state
    sau_st_t next_state; // Next state
    sau_req_t held; // Captured request

    // Combinational arithmetic on the held request
    wire logic signed [16:0] sum_w = 17'(held.a) + 17'(held.b);
    wire logic signed [16:0] diff_w = 17'(held.a) - 17'(held.b);
    wire logic [16:0] sum_sat = sat16(sum_w);
    wire logic [16:0] diff_sat = sat16(diff_w);
    wire logic signed [31:0] prod_w = 32'(held.a) * 32'(held.b);
    wire logic div_zero = (held.b == SAU_ZERO);
    wire logic div_ovf = (held.a == SAU_MIN) && (held.b == SAU_NEG_ONE);
    // Guarded divisor avoids a divide by zero in the datapath
    wire logic signed [16:0] dvsr = div_zero ? 17'sd1 : 17'(held.b);
    wire logic signed [16:0] quo_w = 17'(held.a) / dvsr;
    wire logic signed [16:0] rem_w = 17'(held.a) % dvsr;

    // Result selection
    sau_res_t next_res;
    logic next_out;
    logic next_err;
    always_comb begin
        next_res = '0;
        next_out = 1'b0;
        next_err = 1'b0;
        unique case (held.op)
            SAU_OP_ADD: begin
                next_res.wr_lo = 1'b1;
                next_res.lo = sum_sat[15:0];
                next_out = sum_sat[16];
            end
            SAU_OP_SUB: begin
                next_res.wr_lo = 1'b1;
                next_res.lo = diff_sat[15:0];
                next_out = diff_sat[16];
            end
            SAU_OP_MUL: begin
                next_res.wr_lo = 1'b1;
                next_res.wr_hi = 1'b1;
                next_res.lo = prod_w[15:0];
                next_res.hi = prod_w[31:16];
                next_out = 1'b1;
            end
            SAU_OP_DIV: begin
                if (div_zero) begin
                    next_err = 1'b1;
                end else begin
                    next_res.wr_lo = 1'b1;
                    next_res.wr_hi = 1'b1;
                    // Most negative over minus one clamps positive
                    next_res.lo = div_ovf ? SAU_MAX : quo_w[15:0];
                    next_res.hi = div_ovf ? SAU_ZERO : rem_w[15:0];
                    next_out = 1'b1;
                end
            end
        endcase
    end

    // Start accepted only on a live rung
    wire logic go = rung_i && start_i;

    // Next state: plain operands finish one cycle sooner
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: if (go) next_state = req_i.plain ? ST_DONE : ST_WAIT;
            ST_WAIT: next_state = rung_i ? ST_DONE : ST_IDLE;
            ST_DONE: next_state = ST_IDLE;
        endcase
    end

    // State and request capture
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state <= ST_IDLE;
            held <= '0;
        end else begin
            state <= next_state;
            if (state == ST_IDLE && go) held <= req_i;
        end
    end

    // Registered outputs: rung off forces no write and output off
    wire logic fire = (state == ST_DONE) && rung_i;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            res_o <= '0;
            done_o <= 1'b0;
            out_o <= 1'b0;
        end else begin
            res_o <= fire ? next_res : '0;
            done_o <= fire;
            out_o <= fire && next_out;
        end
    end

    // Error flag is sticky until reset
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            division_error_flag_o <= 1'b0;
        end else if (fire && next_err) begin
            division_error_flag_o <= 1'b1;
        end
    end

    // Checks
    a_rung_off_quiet: assert property (@(posedge clk_i) disable iff (reset_i)
        !$past(rung_i) |-> !out_o && !res_o.wr_lo)
        else $error("output or write with rung off");
    a_add_sat_max: assert property (@(posedge clk_i) disable iff (reset_i)
        fire && held.op == SAU_OP_ADD && sum_w > 17'sd32767
        |=> res_o.lo == SAU_MAX && out_o)
        else $error("add overflow not clamped");
    a_sub_value: assert property (@(posedge clk_i) disable iff (reset_i)
        fire && held.op == SAU_OP_SUB && !diff_sat[16]
        |=> res_o.lo == 16'(held.a - held.b) && !out_o)
        else $error("subtract result wrong");
    a_sub_exact: assert property (@(posedge clk_i) disable iff (reset_i)
        fire && held.op == SAU_OP_SUB && diff_w >= -17'sd32768
        && diff_w <= 17'sd32767 |=> !out_o)
        else $error("in range subtract flagged");
    a_sub_over: assert property (@(posedge clk_i) disable iff (reset_i)
        fire && held.op == SAU_OP_SUB && diff_w > 17'sd32767
        |=> res_o.lo == SAU_MAX && out_o)
        else $error("subtract overflow not clamped");
    a_sub_under: assert property (@(posedge clk_i) disable iff (reset_i)
        fire && held.op == SAU_OP_SUB && diff_w < -17'sd32768
        |=> res_o.lo == SAU_MIN && out_o)
        else $error("subtract underflow not clamped");
    a_mul_product: assert property (@(posedge clk_i) disable iff (reset_i)
        fire && held.op == SAU_OP_MUL
        |=> {res_o.hi, res_o.lo} == $past(prod_w) && out_o)
        else $error("product wrong");
    a_mul_halves: assert property (@(posedge clk_i) disable iff (reset_i)
        fire && held.op == SAU_OP_MUL |=> res_o.wr_hi && res_o.wr_lo)
        else $error("product halves not written");
    a_div_zero: assert property (@(posedge clk_i) disable iff (reset_i)
        fire && held.op == SAU_OP_DIV && div_zero
        |=> division_error_flag_o && !out_o && !res_o.wr_lo)
        else $error("zero divisor mishandled");
    a_div_result: assert property (@(posedge clk_i) disable iff (reset_i)
        fire && held.op == SAU_OP_DIV && !div_zero && !div_ovf
        |=> res_o.lo == $past(quo_w[15:0]) && out_o)
        else $error("quotient wrong");
    a_div_ovf: assert property (@(posedge clk_i) disable iff (reset_i)
        fire && held.op == SAU_OP_DIV && div_ovf
        |=> res_o.lo == SAU_MAX && res_o.hi == SAU_ZERO)
        else $error("divide overflow not clamped");
    a_fast_path: assert property (@(posedge clk_i) disable iff (reset_i)
        state == ST_IDLE && go && req_i.plain && rung_i ##1 rung_i
        |=> done_o)
        else $error("plain operands not fast");
    a_slow_path: assert property (@(posedge clk_i) disable iff (reset_i)
        state == ST_IDLE && go && !req_i.plain |=> !done_o ##1 !done_o)
        else $error("slow path too fast");

    // Signed views of the two result words for the checks below
    wire logic signed [15:0] res_lo_s = res_o.lo; // Base word
    wire logic signed [15:0] res_hi_s = res_o.hi; // Next word

    // Add underflow clamps to the most negative value
    a_add_sat_min: assert property (@(posedge clk_i)
        disable iff (reset_i)
        fire && held.op == SAU_OP_ADD && sum_w < -17'sd32768
        |=> res_o.lo == SAU_MIN && out_o)
        else $error("add underflow not clamped");
    // Add in range stores the exact sum with the output off
    a_add_exact: assert property (@(posedge clk_i)
        disable iff (reset_i)
        fire && held.op == SAU_OP_ADD && sum_w >= -17'sd32768
        && sum_w <= 17'sd32767 |=> res_lo_s == held.a + held.b && !out_o)
        else $error("in range add wrong");
    // Add writes only the base word
    a_add_lo_only: assert property (@(posedge clk_i)
        disable iff (reset_i)
        fire && held.op == SAU_OP_ADD
        |=> res_o.wr_lo && !res_o.wr_hi)
        else $error("add wrote wrong words");
    // Subtract writes only the base word
    a_sub_lo_only: assert property (@(posedge clk_i)
        disable iff (reset_i)
        fire && held.op == SAU_OP_SUB
        |=> res_o.wr_lo && !res_o.wr_hi)
        else $error("subtract wrote wrong words");
    // Quotient times divisor plus remainder gives back the dividend
    a_div_identity: assert property (@(posedge clk_i)
        disable iff (reset_i)
        fire && held.op == SAU_OP_DIV && !div_zero && !div_ovf
        |=> 32'(res_lo_s) * 32'(held.b) + 32'(res_hi_s) == 32'(held.a))
        else $error("quotient and remainder inconsistent");
    // Truncation toward zero leaves the remainder with the dividend sign
    a_div_rem_sign: assert property (@(posedge clk_i)
        disable iff (reset_i)
        fire && held.op == SAU_OP_DIV && !div_zero
        |=> res_hi_s == SAU_ZERO || res_hi_s[15] == held.a[15])
        else $error("remainder sign wrong");
    // Rung lost while waiting aborts with no result
    a_wait_abort: assert property (@(posedge clk_i)
        disable iff (reset_i)
        state == ST_WAIT && !rung_i
        |=> !done_o ##1 !done_o)
        else $error("aborted operation completed");
    // Error flag holds until reset
    a_err_sticky: assert property (@(posedge clk_i)
        disable iff (reset_i)
        division_error_flag_o
        |=> division_error_flag_o)
        else $error("error flag cleared");
    // Error flag rises only on a zero divisor
    a_err_cause: assert property (@(posedge clk_i)
        disable iff (reset_i)
        !(fire && held.op == SAU_OP_DIV && div_zero) && !division_error_flag_o
        |=> !division_error_flag_o)
        else $error("error flag set without cause");
    // Completion is a single-cycle pulse
    a_done_pulse: assert property (@(posedge clk_i)
        disable iff (reset_i)
        done_o
        |=> !done_o)
        else $error("done longer than one cycle");
    // Operation output only comes with a completion
    a_out_needs_done: assert property (@(posedge clk_i)
        disable iff (reset_i)
        out_o
        |-> done_o)
        else $error("output without completion");
    // Writes only come with a completion
    a_write_needs_done: assert property (@(posedge clk_i)
        disable iff (reset_i)
        res_o.wr_lo || res_o.wr_hi
        |-> done_o)
        else $error("write without completion");
    // A strobe while busy leaves the captured request alone
    a_busy_ignored: assert property (@(posedge clk_i)
        disable iff (reset_i)
        start_i && state != ST_IDLE
        |=> $stable(held))
        else $error("request taken while busy");

    // Corner cases: saturating divide, add saturation, subtract underflow, multiply, zero divisor
    c_div_ovf: cover property (@(posedge clk_i)
        fire && held.op == SAU_OP_DIV && div_ovf);
    c_add_sat: cover property (@(posedge clk_i)
        fire && held.op == SAU_OP_ADD && sum_sat[16]);
    c_sub_under: cover property (@(posedge clk_i)
        fire && held.op == SAU_OP_SUB && diff_w < -17'sd32768);
    c_mul: cover property (@(posedge clk_i) fire && held.op == SAU_OP_MUL);
    c_div_zero: cover property (@(posedge clk_i)
        fire && held.op == SAU_OP_DIV && div_zero);

endmodule : sau_unit

// [sau_seq_model.sv]
// Sequencer model: issues one request and keeps the two result words.
// Assumes the unit answers within five cycles of taking a request.
`timescale 1ns/1ns
module sau_seq_model
    import sau_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Answer from the unit
    input wire sau_res_t res_i,
    input wire logic done_i,
    input wire logic out_i,
    // Request to the unit
    output logic rung_o,
    output logic start_o,
    output sau_req_t req_o
);
    logic [15:0] word_c; // Base destination word
    logic [15:0] word_c1; // Next destination word

    // Idle request lines at time zero
    initial begin
        rung_o = 1'b0;
        start_o = 1'b0;
        req_o = '0;
    end

    // Write back whatever the unit hands over
    always @(posedge clk_i) begin
        if (res_i.wr_lo === 1'b1) word_c <= res_i.lo;
        if (res_i.wr_hi === 1'b1) word_c1 <= res_i.hi;
    end

    // One request; rung may drop right after the taking edge
    task issue(input sau_op_t op, input logic plain, input logic [15:0] a,
               input logic [15:0] b, input logic drop, output int lat,
               output logic out);
        int k;
        lat = 0;
        out = 1'b0;
        word_c = 16'h5a5a;
        word_c1 = 16'ha5a5;
        @(posedge clk_i);
        rung_o <= 1'b1;
        start_o <= 1'b1;
        req_o <= '{op, plain, a, b};
        @(posedge clk_i);
        start_o <= 1'b0;
        if (drop) rung_o <= 1'b0;
        // Count edges from the taking edge (zero) until done is sampled
        // high; done launched at edge k is sampled 1 ns after edge k and recorded as k + 1
        for (k = 1; k <= 5; k++) begin
            @(posedge clk_i);
            #1;
            if (done_i === 1'b1 && lat == 0) lat = k + 1;
            if (out_i === 1'b1) out = 1'b1;
        end
        @(posedge clk_i);
        rung_o <= 1'b0;
        // Released operands show a changed pattern, not the last value
        req_o <= ~req_o;
    endtask : issue
endmodule : sau_seq_model

// [signed_arith_unit_test.sv]
// Testbench for the signed arithmetic unit, with a sequencer model.
// Assumes the unit answers as the hand-over contract describes.
`timescale 1ns/1ns
module signed_arith_unit_test
    import sau_pkg::*;
;
    logic clk_i; // System clock
    logic reset_i; // Synchronous reset
    logic rung; // Rung input
    logic start; // Request strobe
    sau_req_t req; // Request carrier
    sau_res_t res; // Result carrier
    logic done; // Result valid
    logic out; // Operation output
    logic err_flag; // Division error flag
    int fail_count = 0; // Mismatches
    int total_checks = 0; // Comparisons

    sau_unit dut (.clk_i(clk_i), .reset_i(reset_i), .rung_i(rung),
        .start_i(start), .req_i(req), .res_o(res), .done_o(done),
        .out_o(out), .division_error_flag_o(err_flag));
    sau_seq_model seq (.clk_i(clk_i), .res_i(res), .done_i(done),
        .out_i(out), .rung_o(rung), .start_o(start), .req_o(req));

    // Clock of 4 ns
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // Compare one value
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Run one operation; lat of -1 skips the latency check
    task op(input sau_op_t o, input logic p, input logic [15:0] a,
            input logic [15:0] b, input logic [15:0] lo,
            input logic [15:0] hi, input logic ou, input int lat);
        int l;
        logic q;
        seq.issue(o, p, a, b, 1'b0, l, q);
        if (lat >= 0) chk(l, lat);
        chk(seq.word_c, lo);
        chk(seq.word_c1, hi);
        chk(q, ou);
    endtask : op

    // Saturating add in both directions
    task t_add;
        op(SAU_OP_ADD, 1'b1, 16'h2710, 16'h65a8, 16'h7fff, 16'ha5a5, 1, 2);
        op(SAU_OP_ADD, 1'b0, 16'h8000, 16'hffff, 16'h8000, 16'ha5a5, 1, 3);
    endtask : t_add

    // Subtract in range, underflow and overflow
    task t_sub;
        op(SAU_OP_SUB, 1'b1, 16'hc2bc, 16'h09f4, 16'hb8c8, 16'ha5a5, 0, 2);
        op(SAU_OP_SUB, 1'b1, 16'h0005, 16'h0007, 16'hfffe, 16'ha5a5, 0, 2);
        op(SAU_OP_SUB, 1'b1, 16'h9bac, 16'h5814, 16'h8000, 16'ha5a5, 1, 2);
        op(SAU_OP_SUB, 1'b0, 16'h7fff, 16'hffff, 16'h7fff, 16'ha5a5, 1, 3);
    endtask : t_sub

    // Double-length product, both halves
    task t_mul;
        op(SAU_OP_MUL, 1'b1, 16'h5bc7, 16'h3195, 16'h81d3, 16'h11c6, 1, 2);
        op(SAU_OP_MUL, 1'b0, 16'h8000, 16'h8000, 16'h0000, 16'h4000, 1, 3);
    endtask : t_mul

    // Quotient, remainder, corner case and zero divisor
    task t_div;
        op(SAU_OP_DIV, 1'b1, 16'h971a, 16'h0145, 16'hffae, 16'hff34, 1, 2);
        op(SAU_OP_DIV, 1'b1, 16'h0007, 16'hfffe, 16'hfffd, 16'h0001, 1, 2);
        op(SAU_OP_DIV, 1'b0, 16'h8000, 16'hffff, 16'h7fff, 16'h0000, 1, 3);
        chk(err_flag, 1'b0);
        op(SAU_OP_DIV, 1'b1, 16'h1234, 16'h0000, 16'h5a5a, 16'ha5a5, 0, -1);
        chk(err_flag, 1'b1);
    endtask : t_div

    // Rung dropped after taking: nothing written, output stays off
    task t_off;
        int l;
        logic q;
        seq.issue(SAU_OP_MUL, 1'b0, 16'h0003, 16'h0004, 1'b1, l, q);
        chk(l, 0);
        chk(seq.word_c, 16'h5a5a);
        chk(q, 1'b0);
    endtask : t_off

    // Verdict and end of run
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    // Main sequence
    initial begin
        reset_i = 1'b1;
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        t_add();
        t_sub();
        t_off();
        t_mul();
        t_div();
        finish_test();
    end

    // Watchdog against a hang
    initial begin
        #(4 * 2000);
        fail_count++;
        finish_test();
    end
endmodule : signed_arith_unit_test
